// ===== verilog/ois_regs.svh
// Constants for the octal input serializer: timing counts and reset values
`ifndef OIS_REGS_SVH
`define OIS_REGS_SVH

// Sample clock period in ns
`define OIS_CLK_NS 8
// Nanoseconds in one millisecond
`define OIS_NS_PER_MS 1000000
// Short debounce interval in ms
`define OIS_DB_SHORT_MS 1
// Long debounce interval in ms
`define OIS_DB_LONG_MS 3
// Number of field channels and shift stages
`define OIS_CHANNELS 8
// Depth of the shift event buffer
`define OIS_FIFO_DEPTH 8
// Reset value of the shift register
`define OIS_SHREG_RST 8'h00
// Reset value of the filtered inputs
`define OIS_FILT_RST 8'h00

`endif

// ===== verilog/ois_pkg.sv
// Types shared by the octal input serializer
package ois_pkg;

  // Debounce interval chosen by the two select pins
  typedef enum logic [1:0] {
    OIS_DB_LONG,
    OIS_DB_SHORT,
    OIS_DB_BYPASS,
    OIS_DB_RSVD
  } ois_db_mode_t;

  // Select pins read high when left open
  function automatic ois_db_mode_t ois_db_decode(input logic hi,
                                                 input logic lo);
    ois_db_mode_t m;
    m = OIS_DB_RSVD;
    case ({hi, lo})
      2'b11: m = OIS_DB_LONG;
      2'b10: m = OIS_DB_SHORT;
      2'b01: m = OIS_DB_BYPASS;
      default: m = OIS_DB_RSVD;
    endcase
    return m;
  endfunction : ois_db_decode

endpackage : ois_pkg

// ===== verilog/ois_serializer.sv
// Octal input serializer: debounce, shift register, event buffer
`timescale 1ns/1ps
`include "ois_regs.svh"

// ****************************************************
// Dual clock event buffer
// ****************************************************

// Gray pointers cross the domains; storage written on the write side only
module ois_afifo #(
  parameter int W = 1,
  parameter int D = `OIS_FIFO_DEPTH
) (
  input wire logic wclk_i,
  input wire logic wrst_i,
  input wire logic wvalid_i,
  output logic wready_o,
  input wire logic [W-1:0] wdata_i,
  input wire logic rclk_i,
  input wire logic rrst_i,
  input wire logic ren_i,
  output logic rvalid_o,
  input wire logic rready_i,
  output logic [W-1:0] rdata_o
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem_q [D];
  logic [AW:0] wbin_q, wbin_d, wgray_q, wgray_d;
  logic [AW:0] rbin_q, rbin_d, rgray_q, rgray_d;
  logic [AW:0] rg1_q, rg2_q, wg1_q, wg2_q;
  logic push, pop;

  // Full when the write pointer is one lap ahead
  always_comb begin
    wready_o = wgray_q != {~rg2_q[AW:AW-1], rg2_q[AW-2:0]};
    push = wvalid_i & wready_o;
    wbin_d = wbin_q + (AW+1)'(push);
    wgray_d = (wbin_d >> 1) ^ wbin_d;
  end

  always_ff @(posedge wclk_i) begin
    if (wrst_i) begin
      wbin_q <= '0;
      wgray_q <= '0;
      rg1_q <= '0;
      rg2_q <= '0;
    end else begin
      wbin_q <= wbin_d;
      wgray_q <= wgray_d;
      rg1_q <= rgray_q;
      rg2_q <= rg1_q;
    end
  end

  // Storage, written only from the link side
  always_ff @(posedge wclk_i) begin
    if (push) begin
      mem_q[wbin_q[AW-1:0]] <= wdata_i;
    end
  end

  // Empty when both pointers agree
  always_comb begin
    rvalid_o = rgray_q != wg2_q;
    pop = ren_i & rready_i & rvalid_o;
    rbin_d = rbin_q + (AW+1)'(pop);
    rgray_d = (rbin_d >> 1) ^ rbin_d;
    rdata_o = mem_q[rbin_q[AW-1:0]];
  end

  // Read side freezes with the enable so back-pressure really builds up
  always_ff @(posedge rclk_i) begin
    if (rrst_i) begin
      rbin_q <= '0;
      rgray_q <= '0;
      wg1_q <= '0;
      wg2_q <= '0;
    end else if (ren_i) begin
      rbin_q <= rbin_d;
      rgray_q <= rgray_d;
      wg1_q <= wgray_q;
      wg2_q <= wg1_q;
    end
  end
endmodule : ois_afifo

// ****************************************************
// Serializer top
// ****************************************************

module ois_serializer #(
  parameter int unsigned DB_SHORT_CYC =
    `OIS_DB_SHORT_MS * (`OIS_NS_PER_MS / `OIS_CLK_NS),
  parameter int unsigned DB_LONG_CYC =
    `OIS_DB_LONG_MS * (`OIS_NS_PER_MS / `OIS_CLK_NS)
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic shift_clk_i,
  input wire logic [`OIS_CHANNELS-1:0] field_inputs_i,
  input wire logic debounce_sel_lo_i,
  input wire logic debounce_sel_hi_i,
  input wire logic parallel_load_n_i,
  input wire logic clock_enable_n_i,
  input wire logic cascade_serial_in_i,
  input wire logic temp_over_i,
  input wire logic temp_shdn_i,
  output logic serial_data_out_o,
  output logic serial_data_out_oe_o,
  output logic overtemp_flag_n_o,
  output logic overtemp_flag_n_oe_o,
  output logic shift_ready_o
);
  localparam int N = `OIS_CHANNELS;
  localparam int SW = N + 5;
  localparam int CW = $clog2(DB_LONG_CYC + 1);
  // Reset pattern of the filtered inputs, one bit per channel
  localparam logic [N-1:0] FILT_RST = `OIS_FILT_RST;

  // ****************************************************
  // Pin synchronisers
  // ****************************************************

  logic [SW-1:0] sync1_q, sync2_q;
  logic [N-1:0] raw_s;
  logic sel_hi_s, sel_lo_s, load_n_s, over_s, shdn_s;

  // Field, select, load and temperature pins are asynchronous to the sample clock
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else if (clk_en_i) begin
      sync1_q <= {field_inputs_i, debounce_sel_hi_i, debounce_sel_lo_i,
                  parallel_load_n_i, temp_over_i, temp_shdn_i};
      sync2_q <= sync1_q;
    end
  end

  assign {raw_s, sel_hi_s, sel_lo_s, load_n_s, over_s, shdn_s} = sync2_q;

  // ****************************************************
  // Debounce filters
  // ****************************************************

  ois_pkg::ois_db_mode_t mode;
  logic [CW-1:0] lim;
  logic [N-1:0] internal_parallel_inputs_q, filt_d;
  logic [CW-1:0] cnt_q [N];
  logic [CW-1:0] cnt_d [N];

  // Reserved code falls back to the longest interval, the safe choice
  always_comb begin
    mode = ois_pkg::ois_db_decode(sel_hi_s, sel_lo_s);
    if (mode == ois_pkg::OIS_DB_SHORT) begin
      lim = CW'(DB_SHORT_CYC);
    end else begin
      lim = CW'(DB_LONG_CYC);
    end
  end

  // One counter per channel, run from the sample clock
  for (genvar g = 0; g < N; g++) begin : g_ch
    always_comb begin
      cnt_d[g] = cnt_q[g];
      filt_d[g] = internal_parallel_inputs_q[g];
      if (mode == ois_pkg::OIS_DB_BYPASS) begin
        filt_d[g] = raw_s[g];
        cnt_d[g] = '0;
      end else if (raw_s[g] == internal_parallel_inputs_q[g]) begin
        cnt_d[g] = '0;
      end else if (cnt_q[g] >= lim - CW'(1)) begin
        filt_d[g] = raw_s[g];
        cnt_d[g] = '0;
      end else begin
        cnt_d[g] = cnt_q[g] + CW'(1);
      end
    end

    always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
        cnt_q[g] <= '0;
        internal_parallel_inputs_q[g] <= FILT_RST[g];
      end else if (clk_en_i) begin
        cnt_q[g] <= cnt_d[g];
        internal_parallel_inputs_q[g] <= filt_d[g];
      end
    end
  end

  // ****************************************************
  // Link side: shift events captured on the host clock
  // ****************************************************

  logic lrst1_q, lrst_q, ready_q, wready, ev_push;
  logic rvalid, ev_bit, pop;

  // Reset reaches the link side through two flops
  always_ff @(posedge shift_clk_i) begin
    lrst1_q <= reset_i;
    lrst_q <= lrst1_q;
    ready_q <= wready & ~lrst_q;
  end

  // Only clocks with load high and enable low are shifts
  assign ev_push = parallel_load_n_i & ~clock_enable_n_i;

  ois_afifo #(
    .W(1),
    .D(`OIS_FIFO_DEPTH)
  ) u_ev (
    .wclk_i(shift_clk_i),
    .wrst_i(lrst_q),
    .wvalid_i(ev_push),
    .wready_o(wready),
    .wdata_i(cascade_serial_in_i),
    .rclk_i(clk_sys_i),
    .rrst_i(reset_i),
    .ren_i(clk_en_i),
    .rvalid_o(rvalid),
    .rready_i(1'b1),
    .rdata_o(ev_bit)
  );

  assign shift_ready_o = ready_q;

  // ****************************************************
  // Shift register and output drivers
  // ****************************************************

  logic [N-1:0] shreg_q, shreg_d;
  logic flag_n_q, flag_n_d, sdo_oe_q, flag_oe_q, oe_d;

  // Events that arrive while loading are drained and dropped
  assign pop = clk_en_i & rvalid;

  always_comb begin
    shreg_d = shreg_q;
    if (!load_n_s) begin
      shreg_d = internal_parallel_inputs_q;
    end else if (pop) begin
      shreg_d = {shreg_q[N-2:0], ev_bit};
    end
  end

  // Driver off above the second trip; pull-down keeps flag low
  always_comb begin
    oe_d = ~shdn_s;
    flag_n_d = ~over_s & ~shdn_s;
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      shreg_q <= `OIS_SHREG_RST;
      flag_n_q <= 1'b1;
      sdo_oe_q <= 1'b1;
      flag_oe_q <= 1'b1;
    end else if (clk_en_i) begin
      shreg_q <= shreg_d;
      flag_n_q <= flag_n_d;
      sdo_oe_q <= oe_d;
      flag_oe_q <= oe_d;
    end
  end

  assign serial_data_out_o = shreg_q[N-1];
  assign serial_data_out_oe_o = sdo_oe_q;
  assign overtemp_flag_n_o = flag_n_q;
  assign overtemp_flag_n_oe_o = flag_oe_q;

  // ****************************************************
  // Checks
  // ****************************************************

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (reset_i);

  load_follow_a: assert property (
    clk_en_i && !load_n_s |=> shreg_q == $past(internal_parallel_inputs_q))
    else $error("register not following inputs during load");
  hold_reg_a: assert property (
    clk_en_i && load_n_s && !pop |=> $stable(shreg_q))
    else $error("register changed without a shift");
  shift_step_a: assert property (
    clk_en_i && load_n_s && pop
    |=> shreg_q[N-1:1] == $past(shreg_q[N-2:0]))
    else $error("shift did not advance one stage");
  shift_in_a: assert property (
    clk_en_i && load_n_s && pop |=> shreg_q[0] == $past(ev_bit))
    else $error("serial input not taken into first stage");
  bypass_filt_a: assert property (
    clk_en_i && mode == ois_pkg::OIS_DB_BYPASS
    |=> internal_parallel_inputs_q[0] == $past(raw_s[0]))
    else $error("bypass did not pass input");
  stable_wait_a: assert property (
    clk_en_i && mode != ois_pkg::OIS_DB_BYPASS
    && raw_s[0] != internal_parallel_inputs_q[0]
    && cnt_q[0] < lim - CW'(1)
    |=> $stable(internal_parallel_inputs_q[0]))
    else $error("input accepted before interval elapsed");
  hot_flag_a: assert property (
    clk_en_i && over_s |=> !overtemp_flag_n_o)
    else $error("flag not low above first trip");
  shdn_oe_a: assert property (
    clk_en_i && shdn_s |=> !serial_data_out_oe_o && !overtemp_flag_n_oe_o)
    else $error("outputs still driven in shutdown");
  flag_pull_a: assert property (
    !overtemp_flag_n_oe_o |-> !overtemp_flag_n_o)
    else $error("flag not low while undriven");

  load_seen_c: cover property (!load_n_s ##1 load_n_s);
  eight_shift_c: cover property ((pop && load_n_s)[*8]);
  shdn_seen_c: cover property (shdn_s ##1 !serial_data_out_oe_o);
  db_accept_c: cover property (
    mode == ois_pkg::OIS_DB_SHORT ##1 $changed(internal_parallel_inputs_q));
endmodule : ois_serializer

// ===== verification/ois_host_model.sv
// Host shift-link master model for the octal input serializer
`timescale 1ns/1ps
module ois_host_model (
  output logic shift_clk_o,
  output logic parallel_load_n_o,
  output logic clock_enable_n_o,
  output logic cascade_serial_in_o,
  input wire logic serial_data_in_i
);
  // ****************************************************
  // Link driver: clock stands low outside frames
  // ****************************************************
  initial begin
    shift_clk_o = 1'h0;
    parallel_load_n_o = 1'h1;
    clock_enable_n_o = 1'h1;
    cascade_serial_in_o = 1'h1;
  end

  // One 30 ns shift clock period
  task automatic pulse();
    #15 shift_clk_o = 1'h1;
    #15 shift_clk_o = 1'h0;
  endtask : pulse

  // Level of the load line, held by the caller
  task automatic set_load(input logic v);
    parallel_load_n_o = v;
  endtask : set_load

  // Load pulse, then the recovery gap the sampled load needs
  task automatic load(input int ns);
    parallel_load_n_o = 1'h0;
    #(ns);
    parallel_load_n_o = 1'h1;
    #48;
  endtask : load

  // Back to back edges; shifts only when enable is low
  task automatic burst(input int n, input logic ce_n);
    clock_enable_n_o = ce_n;
    repeat (n) pulse();
    clock_enable_n_o = 1'h1;
  endtask : burst

  // Read n bits msb first; the answer lags the edge, so wait it out
  task automatic read(input int n, input logic [15:0] cascade_serial_in,
                      output logic [15:0] bits);
    clock_enable_n_o = 1'h0;
    for (int i = n - 1; i >= 0; i--) begin
      bits[i] = serial_data_in_i;
      cascade_serial_in_o = cascade_serial_in[i];
      pulse();
      #60;
      // Gated edges in mid-frame must not move the data
      if (i == 12) begin
        clock_enable_n_o = 1'h1;
        repeat (2) pulse();
        clock_enable_n_o = 1'h0;
      end
    end
    clock_enable_n_o = 1'h1;
    cascade_serial_in_o = 1'h1;
  endtask : read
endmodule : ois_host_model

// ===== verification/tb_top.sv
// Self-checking bench for the octal input serializer
`timescale 1ns/1ps
module tb_top;
  logic clk_sys_i = 1'h0;
  logic reset_i = 1'h1;
  logic clk_en_i;
  logic [7:0] field;
  logic sel_lo;
  logic sel_hi;
  logic t_over;
  logic t_shdn;
  logic sclk, ld_n, ce_n, cascade_serial_in, sdo, sdo_oe, flag_n, flag_oe, ready, seen;
  logic [15:0] bits;
  int n_errors = 0;
  int n_compared = 0;
  // A released serial line shows the inverse, never a stale level
  wire sdo_w = sdo_oe ? sdo : ~sdo;
  wire flag_w = flag_oe ? flag_n : 1'h0; // Pull-down in shutdown
  // Debounce cases: select pins, glitch length, whether it passes
  logic [1:0] sel_tb [7] = '{2'h2, 2'h2, 2'h3, 2'h3, 2'h1, 2'h0, 2'h0};
  int glen [7] = '{3, 8, 10, 20, 2, 10, 20};
  logic pass_tb [7] = '{1'h0, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0, 1'h1};

  always #4 clk_sys_i = ~clk_sys_i;

  // Short debounce counts keep the run brief
  ois_serializer #(.DB_SHORT_CYC(5), .DB_LONG_CYC(15)) ois_serializer_inst (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .clk_en_i(clk_en_i),
    .shift_clk_i(sclk), .field_inputs_i(field),
    .debounce_sel_lo_i(sel_lo), .debounce_sel_hi_i(sel_hi),
    .parallel_load_n_i(ld_n), .clock_enable_n_i(ce_n),
    .cascade_serial_in_i(cascade_serial_in), .temp_over_i(t_over), .temp_shdn_i(t_shdn),
    .serial_data_out_o(sdo), .serial_data_out_oe_o(sdo_oe),
    .overtemp_flag_n_o(flag_n), .overtemp_flag_n_oe_o(flag_oe),
    .shift_ready_o(ready));

  ois_host_model ois_host_model_inst (.shift_clk_o(sclk),
    .parallel_load_n_o(ld_n), .clock_enable_n_o(ce_n),
    .cascade_serial_in_o(cascade_serial_in), .serial_data_in_i(sdo_w));

  // ****************************************************
  // Shared tasks
  // ****************************************************
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, got, exp);
    end
  endtask : check

  // Inputs move 1 ns after the rising edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : cyc

  task automatic report_and_stop();
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop

  // Whole run needs about 8 us; this leaves ample slack
  initial begin
    #60000;
    n_errors++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    // Open select pins read high through their pull-ups
    clk_en_i = 1'h1;
    field = 8'h00;
    sel_lo = 1'h1;
    sel_hi = 1'h1;
    t_over = 1'h0;
    t_shdn = 1'h0;
    ois_host_model_inst.burst(4, 1'h1);
    cyc(5);
    reset_i = 1'h0;
    cyc(5);
    ois_host_model_inst.burst(3, 1'h1);
    check(16'(ready), 16'h0001);
    // Glitches on channel 7 watched live through the load path
    ois_host_model_inst.set_load(1'h0);
    for (int k = 0; k < 7; k++) begin
      {sel_hi, sel_lo} = sel_tb[k];
      cyc(40);
      seen = 1'h0;
      field = 8'h80;
      cyc(glen[k]);
      field = 8'h00;
      repeat (40) begin
        cyc(1);
        if (sdo_w === 1'h1) seen = 1'h1;
      end
      check(16'(seen), 16'(pass_tb[k]));
    end
    ois_host_model_inst.set_load(1'h1);
    // Capture, then change the field while shifting out
    {sel_hi, sel_lo} = 2'h1;
    field = 8'hA5;
    cyc(10);
    ois_host_model_inst.load(48);
    field = 8'h5A;
    cyc(10);
    ois_host_model_inst.read(16, 16'h3CFF, bits);
    check(bits, 16'hA53C);
    check(16'(sdo_w), 16'h0001);
    // Overtemperature and shutdown
    t_over = 1'h1;
    cyc(5);
    check(16'({flag_w, flag_oe, sdo_oe}), 16'h0003);
    t_shdn = 1'h1;
    cyc(5);
    check(16'({flag_w, flag_oe, sdo_oe}), 16'h0000);
    t_over = 1'h0;
    t_shdn = 1'h0;
    cyc(5);
    check(16'({flag_w, flag_oe, sdo_oe}), 16'h0007);
    // Fill the shift buffer with the sample side frozen, then drain
    ois_host_model_inst.load(48);
    clk_en_i = 1'h0;
    ois_host_model_inst.burst(10, 1'h0);
    check(16'(ready), 16'h0000);
    clk_en_i = 1'h1;
    cyc(40);
    check(16'(sdo_w), 16'h0001);
    // Read pointer needs two link edges to cross, the ready flop a third
    ois_host_model_inst.burst(3, 1'h1);
    check(16'(ready), 16'h0001);
    report_and_stop();
  end
endmodule : tb_top
